// ---- hw/ufh_map.svh ----
// Register offsets, field positions and frame layout for the frame host.
`ifndef UFH_MAP_SVH
`define UFH_MAP_SVH
`define UFH_A_CTRL 8'h00
`define UFH_A_TXCFG 8'h04
`define UFH_A_CHAN 8'h08
`define UFH_A_STAT 8'h0c
`define UFH_A_RXHDR 8'h10
`define UFH_A_RXERR 8'h14
`define UFH_A_IRQS 8'h18
`define UFH_A_IRQM 8'h1c
`define UFH_C_GO 0
`define UFH_C_RXEN 1
`define UFH_C_BM 2
`define UFH_C_PT 3
`define UFH_C_PRST 4
`define UFH_TC_LEN 16
`define UFH_CH_BG 4
`define UFH_HB_RATE 3
`define UFH_HB_LEN 8
`define UFH_HB_SCR 21
`define UFH_HB_BM 23
`define UFH_HB_PT 24
`define UFH_HB_TFC 25
`define UFH_HB_BG 28
`define UFH_HDR_RESV 40'hffe0100007
`define UFH_HDR_LAST 3'h4
`define UFH_MHDR_LAST 4'h9
`define UFH_FCS_LAST 2'h3
`define UFH_TAIL_LAST 2'h2
`define UFH_RATE_MAX 5'h07
`define UFH_BG_MAX 3'h5
`define UFH_HE_MASK 5'h18
`define UFH_RE_MASK 5'h19
`define UFH_I_TXD 0
`define UFH_I_RXH 1
`define UFH_I_RXD 2
`define UFH_I_RXF 3
`define UFH_I_REF 4
`define UFH_CRC_POLY 32'hedb88320
`define UFH_CRC_INIT 32'hffffffff
`define UFH_RESP_OK 2'b00
`define UFH_RESP_ERR 2'b10
`endif

// ---- hw/ufh_pkg.sv ----
// State types of the frame host.
package ufh_pkg;
  typedef enum logic [2:0] {
    T_IDLE, T_HDR, T_MHDR, T_BODY, T_FCS
  } ufh_tx_st_t;
  typedef enum logic [2:0] {
    R_HDR, R_MHDR, R_HERR, R_BODY, R_FCS, R_TAIL
  } ufh_rx_st_t;
endpackage

// ---- hw/ufh_crc32.sv ----
// Byte-wide reflected CRC-32 accumulator for the frame check sequence.
`timescale 1ns/1ps
`include "ufh_map.svh"
module ufh_crc32 (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  din,
  output logic      [31:0] crc
);
  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;

  // Bit 0 of each octet enters the register first.
  always_comb begin
    nxt_crc = crc_ff;
    if (init) begin
      nxt_crc = `UFH_CRC_INIT;
    end else if (en) begin
      for (int i = 0; i < 8; i++) begin
        nxt_crc = (nxt_crc >> 1) ^
                  ((nxt_crc[0] ^ din[i]) ? `UFH_CRC_POLY : 32'h0);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      crc_ff <= `UFH_CRC_INIT;
    end else begin
      crc_ff <= nxt_crc;
    end
  end

  assign crc = crc_ff;
endmodule

// ---- hw/ufh_frame_host.sv ----
// Frame host: builds transmit frames and parses receive frames.
// Overview of operation
// R01: Frame octets travel low bit first, octet zero first.
// R02: FCS carries a0 in bit 31, sent lowest octet first.
// R03: A zero length forces the rate field to zero.
// R04: Length counts payload octets only; zero length omits the FCS.
// R05: Length is twelve unsigned bits at header bits 8 to 19.
// R06: Scrambler seed clears at initialisation and on every PHY reset.
// R07: Scrambler seed advances by one, modulo four, per frame.
// R08: Reserved header bits are sent as zero.
// R09: Rate codes 0 to 7 only; higher codes are never sent.
// R10: Burst bit is one only before minimum burst spacing.
// R11: Preamble bit names the next frame's preamble, one for burst.
// R12: Time-frequency codes 1 to 7 sent as T1..T3; 000 never.
// R13: Band-group bit is one for odd groups, zero for even.
// R14: Code and band-group bit come from the transmit channel register.
// R15: PHY returns all header control fields in each received frame.
// R16: PHY reports header faults in five bits: 3 rate, 4 check.
// R17: PHY ends each frame with five result bits: 0, 3, 4. The host reads no result octet after a header fault.
// R18: Reserved bits of a received header are ignored.
// R19: Header, Frame_header_bytes, payload then FCS, one octet per qualified clock.
`timescale 1ns/1ps
`include "ufh_map.svh"
module ufh_frame_host (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic             phy_reset_n,
  output logic             phy_tx_en,
  output logic             phy_rx_en,
  input  wire logic [7:0]  phy_data_i,
  output logic      [7:0]  phy_data_o,
  output logic             phy_data_oe,
  input  wire logic        phy_den_i,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_byte_valid,
  output logic             tx_byte_ready,
  output logic      [7:0]  rx_byte,
  output logic             rx_byte_valid
);
  logic [7:0]  d1_ff, d2_ff;
  logic        e1_ff, e2_ff;
  logic [4:0]  ctrl_ff, nxt_ctrl;
  logic [4:0]  rate_ff, nxt_rate;
  logic [11:0] len_ff, nxt_len;
  logic [2:0]  tfc_ff, nxt_tfc;
  logic [2:0]  bg_ff, nxt_bg;
  logic [4:0]  irqm_ff, nxt_irqm;
  logic [4:0]  irqs_ff, nxt_irqs;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic        rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic        wr, rd, go, go_ok, go_bad;
  logic [31:0] m, wnew;
  logic [4:0]  ev;
  ufh_pkg::ufh_tx_st_t tst_ff, nxt_tst;
  logic [11:0] tcnt_ff, nxt_tcnt;
  logic [11:0] tlen_ff, nxt_tlen;
  logic [39:0] hdr_ff, nxt_hdr, hdr;
  logic [7:0]  tout_ff, nxt_tout;
  logic [1:0]  seed_ff, nxt_seed;
  logic        need_user, adv, tdone;
  logic [4:0]  eff_rate;
  logic [31:0] crc;
  ufh_pkg::ufh_rx_st_t rst_ff, nxt_rst;
  logic [11:0] rcnt_ff, nxt_rcnt;
  logic [11:0] rlen_ff, nxt_rlen;
  logic [31:0] rxh_ff, nxt_rxh;
  logic [24:0] rxhdr_ff, nxt_rxhdr;
  logic [4:0]  herr_ff, nxt_herr;
  logic [4:0]  rres_ff, nxt_rres;
  logic [7:0]  rb_ff, nxt_rb;
  logic        rbv_ff, nxt_rbv;
  logic        rin;
  logic [39:0] full;
  logic [2:0]  rev;

  function automatic logic [31:0] regval(input logic [7:0] a);
    case (a)
      `UFH_A_CTRL:  regval = {27'h0, ctrl_ff};
      `UFH_A_TXCFG: regval = {4'h0, len_ff, 11'h0, rate_ff};
      `UFH_A_CHAN:  regval = {25'h0, bg_ff, 1'b0, tfc_ff};
      `UFH_A_STAT:  regval = {28'h0, seed_ff, rst_ff != ufh_pkg::R_HDR,
                              tst_ff != ufh_pkg::T_IDLE};
      `UFH_A_RXHDR: regval = {7'h0, rxhdr_ff};
      `UFH_A_RXERR: regval = {19'h0, rres_ff, 3'h0, herr_ff};
      `UFH_A_IRQS:  regval = {27'h0, irqs_ff};
      `UFH_A_IRQM:  regval = {27'h0, irqm_ff};
      default:      regval = 32'h0;
    endcase
  endfunction

  function automatic logic known(input logic [7:0] a);
    known = (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
  endfunction

  // Two-stage synchronisers for the PHY data bus and its qualifier.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      d1_ff <= 8'h00;
      d2_ff <= 8'h00;
      e1_ff <= 1'b0;
      e2_ff <= 1'b0;
    end else begin
      d1_ff <= phy_data_i;
      d2_ff <= d1_ff;
      e1_ff <= phy_den_i;
      e2_ff <= e1_ff;
    end
  end

  assign wr = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign rd = s_axi_arvalid && !rvalid_ff;
  assign s_axi_awready = wr;
  assign s_axi_wready = wr;
  assign s_axi_arready = rd;
  assign m = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
              {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  always_comb begin
    wnew = (regval(s_axi_awaddr) & ~m) | (s_axi_wdata & m);
  end
  assign go = wr && s_axi_awaddr == `UFH_A_CTRL && wnew[`UFH_C_GO];
  // R03 zero length rate.
  assign eff_rate = (len_ff == 12'h0) ? 5'h00 : rate_ff;
  // R09 R12 R13 refuse reserved codes.
  assign go_bad = go && (tst_ff != ufh_pkg::T_IDLE ||
                  eff_rate > `UFH_RATE_MAX || tfc_ff == 3'h0 ||
                  bg_ff == 3'h0 || bg_ff > `UFH_BG_MAX);
  assign go_ok = go && !go_bad;
  assign irq = |(irqs_ff & irqm_ff);

  // Register file, bus answers and sticky event bits.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_rate = rate_ff;
    nxt_len = len_ff;
    nxt_tfc = tfc_ff;
    nxt_bg = bg_ff;
    nxt_irqm = irqm_ff;
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_irqs = irqs_ff;
    if (wr) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = known(s_axi_awaddr) ? `UFH_RESP_OK : `UFH_RESP_ERR;
      case (s_axi_awaddr)
        `UFH_A_CTRL:  nxt_ctrl = {wnew[4:1], 1'b0};
        `UFH_A_TXCFG: begin
          nxt_rate = wnew[4:0];
          nxt_len = wnew[`UFH_TC_LEN +: 12];
        end
        `UFH_A_CHAN: begin
          nxt_tfc = wnew[2:0];
          nxt_bg = wnew[`UFH_CH_BG +: 3];
        end
        `UFH_A_IRQM:  nxt_irqm = wnew[4:0];
        default:      nxt_irqm = irqm_ff;
      endcase
    end
    if (rd) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = regval(s_axi_araddr);
      nxt_rresp = known(s_axi_araddr) ? `UFH_RESP_OK : `UFH_RESP_ERR;
      if (s_axi_araddr == `UFH_A_IRQS) begin
        nxt_irqs = 5'h00;
      end
    end
    nxt_irqs = nxt_irqs | ev;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_ff <= 5'h00;
      rate_ff <= 5'h00;
      len_ff <= 12'h000;
      tfc_ff <= 3'h0;
      bg_ff <= 3'h0;
      irqm_ff <= 5'h00;
      irqs_ff <= 5'h00;
      bvalid_ff <= 1'b0;
      bresp_ff <= `UFH_RESP_OK;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `UFH_RESP_OK;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rate_ff <= nxt_rate;
      len_ff <= nxt_len;
      tfc_ff <= nxt_tfc;
      bg_ff <= nxt_bg;
      irqm_ff <= nxt_irqm;
      irqs_ff <= nxt_irqs;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign ev = {go_bad, rev, tdone};
  assign phy_reset_n = !ctrl_ff[`UFH_C_PRST];
  assign phy_rx_en = ctrl_ff[`UFH_C_RXEN];

  // R08 reserved zero: every bit not named below stays clear.
  always_comb begin
    hdr = 40'h0;
    hdr[`UFH_HB_RATE +: 5] = eff_rate;
    // R05 length field placement.
    hdr[`UFH_HB_LEN +: 12] = len_ff;
    hdr[`UFH_HB_SCR +: 2] = seed_ff;
    // R10 R11 burst and preamble bits.
    hdr[`UFH_HB_BM] = ctrl_ff[`UFH_C_BM];
    hdr[`UFH_HB_PT] = ctrl_ff[`UFH_C_PT];
    // R14 channel derived: T1 is code bit 0, R12 R13 encodings.
    hdr[`UFH_HB_TFC +: 3] = tfc_ff;
    hdr[`UFH_HB_BG] = bg_ff[0];
  end

  assign need_user = (tst_ff == ufh_pkg::T_HDR &&
                      tcnt_ff[2:0] == `UFH_HDR_LAST) ||
                     (tst_ff == ufh_pkg::T_MHDR &&
                      (tcnt_ff[3:0] != `UFH_MHDR_LAST || tlen_ff != 12'h0)) ||
                     (tst_ff == ufh_pkg::T_BODY &&
                      tcnt_ff != tlen_ff - 12'h1);
  assign adv = e2_ff && tst_ff != ufh_pkg::T_IDLE &&
               (!need_user || tx_byte_valid);
  assign tx_byte_ready = e2_ff && tst_ff != ufh_pkg::T_IDLE && need_user;

  // R19 octet order: header, Frame_header_bytes, payload, FCS.
  always_comb begin
    nxt_tst = tst_ff;
    nxt_tcnt = tcnt_ff;
    nxt_tlen = tlen_ff;
    nxt_hdr = hdr_ff;
    nxt_tout = tout_ff;
    tdone = 1'b0;
    // R06 R07 seed cleared by PHY reset, stepped per frame.
    nxt_seed = ctrl_ff[`UFH_C_PRST] ? 2'h0 :
               go_ok ? seed_ff + 2'h1 : seed_ff;
    if (go_ok) begin
      nxt_tst = ufh_pkg::T_HDR;
      nxt_tcnt = 12'h0;
      nxt_tlen = len_ff;
      nxt_hdr = hdr;
      nxt_tout = hdr[7:0];
    end else if (adv) begin
      nxt_tcnt = tcnt_ff + 12'h1;
      nxt_tout = tx_byte;
      unique case (tst_ff)
        ufh_pkg::T_HDR: begin
          // R01 low octet of the header vector goes first.
          nxt_tout = 8'(hdr_ff >> {tcnt_ff[2:0] + 3'h1, 3'h0});
          if (tcnt_ff[2:0] == `UFH_HDR_LAST) begin
            nxt_tst = ufh_pkg::T_MHDR;
            nxt_tcnt = 12'h0;
            nxt_tout = tx_byte;
          end
        end
        ufh_pkg::T_MHDR: begin
          if (tcnt_ff[3:0] == `UFH_MHDR_LAST) begin
            nxt_tcnt = 12'h0;
            // R04 zero length ends without FCS.
            nxt_tst = (tlen_ff == 12'h0) ? ufh_pkg::T_IDLE
                                         : ufh_pkg::T_BODY;
            tdone = tlen_ff == 12'h0;
          end
        end
        ufh_pkg::T_BODY: begin
          if (tcnt_ff == tlen_ff - 12'h1) begin
            nxt_tst = ufh_pkg::T_FCS;
            nxt_tcnt = 12'h0;
            // R02 complemented CRC, lowest octet first.
            nxt_tout = ~crc[7:0];
          end
        end
        ufh_pkg::T_FCS: begin
          nxt_tout = 8'(~crc >> {tcnt_ff[1:0] + 2'h1, 3'h0});
          if (tcnt_ff[1:0] == `UFH_FCS_LAST) begin
            nxt_tst = ufh_pkg::T_IDLE;
            tdone = 1'b1;
          end
        end
        ufh_pkg::T_IDLE: nxt_tst = ufh_pkg::T_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tst_ff <= ufh_pkg::T_IDLE;
      tcnt_ff <= 12'h0;
      tlen_ff <= 12'h0;
      hdr_ff <= 40'h0;
      tout_ff <= 8'h00;
      seed_ff <= 2'h0;
    end else begin
      tst_ff <= nxt_tst;
      tcnt_ff <= nxt_tcnt;
      tlen_ff <= nxt_tlen;
      hdr_ff <= nxt_hdr;
      tout_ff <= nxt_tout;
      seed_ff <= nxt_seed;
    end
  end

  ufh_crc32 u_crc (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .init    (go_ok),
    .en      (tx_byte_ready && tx_byte_valid),
    .din     (tx_byte),
    .crc     (crc)
  );

  assign phy_tx_en = tst_ff != ufh_pkg::T_IDLE;
  assign phy_data_oe = phy_tx_en;
  assign phy_data_o = tout_ff;

  assign rin = e2_ff && phy_rx_en && !phy_tx_en;
  assign full = {d2_ff, rxh_ff};

  // R15 R16 R17 receive layout with header and result octets.
  always_comb begin
    nxt_rst = rst_ff;
    nxt_rcnt = rcnt_ff;
    nxt_rlen = rlen_ff;
    nxt_rxh = rxh_ff;
    nxt_rxhdr = rxhdr_ff;
    nxt_herr = herr_ff;
    nxt_rres = rres_ff;
    nxt_rb = rb_ff;
    nxt_rbv = 1'b0;
    rev = 3'h0;
    if (!phy_rx_en) begin
      nxt_rst = ufh_pkg::R_HDR;
      nxt_rcnt = 12'h0;
    end else if (rin) begin
      nxt_rcnt = rcnt_ff + 12'h1;
      unique case (rst_ff)
        ufh_pkg::R_HDR: begin
          nxt_rxh[{rcnt_ff[1:0], 3'h0} +: 8] = d2_ff;
          if (rcnt_ff[2:0] == `UFH_HDR_LAST) begin
            // R18 reserved header bits are dropped.
            nxt_rxhdr = {full[`UFH_HB_BG], full[`UFH_HB_TFC +: 3],
                         full[`UFH_HB_PT], full[`UFH_HB_BM],
                         full[`UFH_HB_SCR +: 2], full[`UFH_HB_LEN +: 12],
                         full[`UFH_HB_RATE +: 5]};
            nxt_rlen = full[`UFH_HB_LEN +: 12];
            nxt_rst = ufh_pkg::R_MHDR;
            nxt_rcnt = 12'h0;
            rev[`UFH_I_RXH - 1] = 1'b1;
          end
        end
        ufh_pkg::R_MHDR: begin
          nxt_rb = d2_ff;
          nxt_rbv = 1'b1;
          if (rcnt_ff[3:0] == `UFH_MHDR_LAST) begin
            nxt_rst = ufh_pkg::R_HERR;
          end
        end
        ufh_pkg::R_HERR: begin
          nxt_herr = d2_ff[4:0] & `UFH_HE_MASK;
          nxt_rcnt = 12'h0;
          nxt_rst = (rlen_ff == 12'h0) ? ufh_pkg::R_TAIL
                                       : ufh_pkg::R_BODY;
          if ((d2_ff[4:0] & `UFH_HE_MASK) != 5'h00) begin
            nxt_rst = ufh_pkg::R_HDR;
            rev[`UFH_I_RXF - 1] = 1'b1;
          end
        end
        ufh_pkg::R_BODY: begin
          nxt_rb = d2_ff;
          nxt_rbv = 1'b1;
          if (rcnt_ff == rlen_ff - 12'h1) begin
            nxt_rst = ufh_pkg::R_FCS;
            nxt_rcnt = 12'h0;
          end
        end
        ufh_pkg::R_FCS: begin
          nxt_rb = d2_ff;
          nxt_rbv = 1'b1;
          if (rcnt_ff[1:0] == `UFH_FCS_LAST) begin
            nxt_rst = ufh_pkg::R_TAIL;
            nxt_rcnt = 12'h0;
          end
        end
        ufh_pkg::R_TAIL: begin
          if (rcnt_ff[1:0] == `UFH_TAIL_LAST) begin
            nxt_rres = d2_ff[4:0] & `UFH_RE_MASK;
            nxt_rst = ufh_pkg::R_HDR;
            nxt_rcnt = 12'h0;
            rev[`UFH_I_RXD - 1] = 1'b1;
            rev[`UFH_I_RXF - 1] = (d2_ff[4:0] & `UFH_RE_MASK) != 5'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rst_ff <= ufh_pkg::R_HDR;
      rcnt_ff <= 12'h0;
      rlen_ff <= 12'h0;
      rxh_ff <= 32'h0;
      rxhdr_ff <= 25'h0;
      herr_ff <= 5'h00;
      rres_ff <= 5'h00;
      rb_ff <= 8'h00;
      rbv_ff <= 1'b0;
    end else begin
      rst_ff <= nxt_rst;
      rcnt_ff <= nxt_rcnt;
      rlen_ff <= nxt_rlen;
      rxh_ff <= nxt_rxh;
      rxhdr_ff <= nxt_rxhdr;
      herr_ff <= nxt_herr;
      rres_ff <= nxt_rres;
      rb_ff <= nxt_rb;
      rbv_ff <= nxt_rbv;
    end
  end

  assign rx_byte = rb_ff;
  assign rx_byte_valid = rbv_ff;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_start;
    go_ok && !ctrl_ff[`UFH_C_PRST];
  endsequence
  sequence s_first;
    tst_ff == ufh_pkg::T_HDR && tcnt_ff == 12'h0 && tout_ff == hdr_ff[7:0];
  endsequence
  property p_seed_step;
    s_start |=> seed_ff == 2'($past(seed_ff) + 2'h1);
  endproperty
  a_seed_step: assert property (p_seed_step) // R07
    else $error("seed did not step");
  property p_seed_clr;
    ctrl_ff[`UFH_C_PRST] |=> seed_ff == 2'h0;
  endproperty
  a_seed_clr: assert property (p_seed_clr) // R06
    else $error("seed not cleared by reset");
  property p_rate_zero;
    tst_ff != ufh_pkg::T_IDLE && tlen_ff == 12'h0
      |-> hdr_ff[`UFH_HB_RATE +: 5] == 5'h00;
  endproperty
  a_rate_zero: assert property (p_rate_zero) // R03
    else $error("nonzero rate with zero length");
  property p_resv;
    tst_ff != ufh_pkg::T_IDLE |-> (hdr_ff & `UFH_HDR_RESV) == 40'h0;
  endproperty
  a_resv: assert property (p_resv) // R08
    else $error("reserved header bit set");
  property p_len;
    s_start |=> hdr_ff[`UFH_HB_LEN +: 12] == $past(len_ff);
  endproperty
  a_len: assert property (p_len) // R05
    else $error("length field misplaced");
  property p_chan;
    s_start |=> hdr_ff[`UFH_HB_TFC +: 3] == $past(tfc_ff) &&
                hdr_ff[`UFH_HB_BG] == $past(bg_ff[0]);
  endproperty
  a_chan: assert property (p_chan) // R14
    else $error("code or band bit not from channel");
  property p_rate_ok;
    tst_ff != ufh_pkg::T_IDLE
      |-> hdr_ff[`UFH_HB_RATE +: 5] <= `UFH_RATE_MAX &&
          hdr_ff[`UFH_HB_TFC +: 3] != 3'h0;
  endproperty
  a_rate_ok: assert property (p_rate_ok) // R09
    else $error("reserved rate or code sent");
  property p_fcs_omit;
    tst_ff == ufh_pkg::T_FCS |-> tlen_ff != 12'h0;
  endproperty
  a_fcs_omit: assert property (p_fcs_omit) // R04
    else $error("FCS sent with zero length");
  property p_order;
    s_start |=> s_first;
  endproperty
  a_order: assert property (p_order) // R19
    else $error("frame did not open with header octet");
endmodule

// ---- testbench/ufh_phy_model.sv ----
// Behavioural PHY model that takes transmit octets and sends receive frames.
`timescale 1ns/1ps
module ufh_phy_model (
  input  wire logic       sys_clk,
  input  wire logic       phy_tx_en,
  input  wire logic [7:0] phy_data_o,
  output logic      [7:0] phy_data_i,
  output logic            phy_den_i
);
  logic [7:0] txq[$];
  int         k;
  initial begin
    phy_data_i = 8'h00;
    phy_den_i  = 1'b0;
    k          = 0;
  end
  always @(posedge sys_clk) begin
    if (phy_tx_en) begin
      txq.push_back(phy_data_o);
      phy_den_i <= 1'b1;
      @(posedge sys_clk);
      phy_den_i <= 1'b0;
      repeat (4 + 5 * (k % 2)) @(posedge sys_clk);
      k++;
    end
  end
  task automatic send_rx(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge sys_clk);
      phy_data_i <= b[i];
      phy_den_i  <= 1'b1;
      @(posedge sys_clk);
      phy_data_i <= ~b[i];
      phy_den_i  <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
endmodule

// ---- testbench/ufh_frame_host_tb_top.sv ----
// Self-checking bench for the frame host.
`timescale 1ns/1ps
`include "ufh_map.svh"
module ufh_frame_host_tb_top;
  logic        sys_clk, sys_rst, irq, phy_reset_n, phy_tx_en, phy_rx_en;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, phy_data_i, phy_data_o;
  logic [7:0]  tx_byte, rx_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, phy_data_oe, phy_den_i;
  logic        tx_byte_valid, tx_byte_ready, rx_byte_valid;
  logic [39:0] h;
  logic [7:0]  b[$];
  logic [7:0]  rxq[$];
  int          error_cnt, compares, idx, rxn;
  ufh_frame_host ufh_frame_host_inst (.sys_clk, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
    .phy_reset_n, .phy_tx_en, .phy_rx_en, .phy_data_i, .phy_data_o,
    .phy_data_oe, .phy_den_i, .tx_byte, .tx_byte_valid, .tx_byte_ready,
    .rx_byte, .rx_byte_valid);
  ufh_phy_model ufh_phy_model_inst (.sys_clk, .phy_tx_en, .phy_data_o,
    .phy_data_i, .phy_den_i);
  assign tx_byte = 8'(idx * 7 + 3);
  always @(posedge sys_clk) begin
    if (tx_byte_ready) idx <= idx + 1;
    if (rx_byte_valid) rxn <= rxn + 1;
    if (rx_byte_valid) rxq.push_back(rx_byte);
  end
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic to();
    error_cnt++;
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (n < 50) begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        n   = 99;
      end
    end
    if (n != 99) to();
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    while (n < 50) begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd  = s_axi_rdata;
        rsp = s_axi_rresp;
        n   = 99;
      end
    end
    if (n != 99) to();
  endtask
  task automatic go(input logic [4:0] rt, input logic [11:0] ln,
                    input logic [2:0] tc, input logic [2:0] bg,
                    input logic [1:0] f);
    wr(`UFH_A_TXCFG, {4'h0, ln, 11'h0, rt});
    wr(`UFH_A_CHAN, {25'h0, bg, 1'b0, tc});
    idx <= 0;
    ufh_phy_model_inst.txq.delete();
    wr(`UFH_A_CTRL, {28'h0, f, 2'b00});
    wr(`UFH_A_CTRL, {28'h0, f, 2'b01});
  endtask
  task automatic frame(input int f, input logic [1:0] sd);
    logic [11:0] ln;
    logic [2:0]  tc, bg;
    logic [31:0] c;
    int          n;
    ln = (f == 2) ? 12'h0 : 12'(f + 1);
    tc = 3'(f % 7 + 1);
    bg = 3'(f % 5 + 1);
    h  = {11'h0, bg[0], tc, f[1], f[0], sd, 1'b0, ln,
          (ln == 0) ? 5'h0 : 5'(f), 3'h0};
    go(5'(f), ln, tc, bg, 2'(f));
    n = 0;
    while (n < 3000 && (phy_tx_en || ufh_phy_model_inst.txq.size() == 0)) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) to();
    chk(ufh_phy_model_inst.txq.size(), 15 + ln + (ln ? 4 : 0));
    for (int i = 0; i < 5; i++) begin
      chk(ufh_phy_model_inst.txq[i], h[8*i+:8]);
    end
    c = 32'hffffffff;
    for (int i = 0; i < 10 + ln; i++) begin
      chk(ufh_phy_model_inst.txq[5+i], 8'(i * 7 + 3));
      c = c ^ 32'(8'(i * 7 + 3));
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    c = ~c;
    for (int i = 0; i < 4 && ln != 0; i++) begin
      chk(ufh_phy_model_inst.txq[15+ln+i], c[8*i+:8]);
    end
    chk(irq, 1'b1);
    rdr(`UFH_A_IRQS);
    chk(rd, 32'h1);
    chk(irq, 1'b0);
  endtask
  initial begin
    sys_rst       = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_araddr  = 8'h00;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hf;
    s_axi_bready  = 1'b1;
    s_axi_rready  = 1'b1;
    tx_byte_valid = 1'b1;
    error_cnt     = 0;
    compares      = 0;
    idx           = 0;
    rxn           = 0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 9; a++) begin
      rdr(8'(a * 4));
      chk(rd, 32'h0);
      chk(rsp, (a == 8) ? `UFH_RESP_ERR : `UFH_RESP_OK);
    end
    wr(8'h24, 32'h1);
    chk(rsp, `UFH_RESP_ERR);
    wr(`UFH_A_IRQM, 32'h1f);
    for (int f = 0; f < 8; f++) begin
      if (f == 5) begin
        wr(`UFH_A_CTRL, 32'h10);
        chk(phy_reset_n, 1'b0);
        wr(`UFH_A_CTRL, 32'h0);
      end
      frame(f, 2'((f < 5) ? f : f - 5));
    end
    wr(`UFH_A_IRQM, 32'h0);
    for (int r = 0; r < 3; r++) begin
      go((r == 0) ? 5'h08 : 5'h01, 12'h4, (r == 1) ? 3'h0 : 3'h1,
         (r == 2) ? 3'h6 : 3'h1, 2'h0);
      repeat (20) @(posedge sys_clk);
      chk(ufh_phy_model_inst.txq.size(), 0);
      chk(irq, 1'b0);
      rdr(`UFH_A_IRQS);
      chk(rd, 32'h10);
    end
    wr(`UFH_A_CTRL, 32'h2);
    h = 40'hffe0100007 | {11'h0, 1'b1, 3'd5, 1'b0, 1'b1, 2'd1, 1'b0,
                          12'd2, 5'd3, 3'h0};
    for (int i = 0; i < 5; i++) b.push_back(h[8*i+:8]);
    for (int i = 0; i < 10; i++) b.push_back(8'(i));
    b = {b, 8'h00, 8'h5a, 8'ha5, 8'h11, 8'h22, 8'h33, 8'h44, 8'h70, 8'h60};
    b.push_back(8'h19);
    ufh_phy_model_inst.send_rx(b);
    repeat (10) @(posedge sys_clk);
    rdr(`UFH_A_RXHDR);
    chk(rd, {7'h0, 1'b1, 3'd5, 1'b0, 1'b1, 2'd1, 12'd2, 5'd3});
    rdr(`UFH_A_RXERR);
    chk(rd, 32'h1900);
    chk(rxn, 16);
    for (int i = 0; i < 16; i++) begin
      chk(rxq[i], b[(i < 10) ? 5 + i : 6 + i]);
    end
    rdr(`UFH_A_IRQS);
    chk(rd & 32'h6, 32'h6);
    b = b[0:14];
    b.push_back(8'h18);
    ufh_phy_model_inst.send_rx(b);
    repeat (10) @(posedge sys_clk);
    rdr(`UFH_A_RXERR);
    chk(rd[4:0], 5'h18);
    rdr(`UFH_A_IRQS);
    chk(rd & 32'h8, 32'h8);
    print_verdict();
  end
endmodule
